// *** hw/cic_core_irq.sv ***
// Core interrupt controller: flags, enables, vectoring sequencer, AHB-Lite slave.
// Assumes the core follows core_o commands and pulses return_from_isr_op once.
`timescale 1ns/1ns
// Contract
// - Any reset leaves interrupts disabled
// - Vector needs global and own enables, group enable for peripherals only
// - Flags set regardless of any enable
// - Clear enable, then flush, push, save, vector
// - Global enable clear only records flags; the code also still wakes Sleep on enabled wake sources
// - Return pops, restores, sets global enable
// - Synchronous latency three or four cycles
// - Asynchronous latency three to five cycles
// - Latency independent of instruction length
// - Pin flag sets Q4-Q1, sampled Q1
// - Only clockless enabled sources wake Sleep
// - Post-sleep instruction runs before vectoring
// - Pin edge select: rising or falling
// - Valid pin edge sets flag, may vector
// - Saved context excludes timeout, power-down bits
// - Summary flag read-only, clears with all
module cic_core_irq
  import cic_pkg::*;
#(
  parameter int N_PCHG = 6,
  parameter logic [7:0] WAKE_MASK_A = 8'hFF,
  parameter logic [7:0] WAKE_MASK_B = 8'hFF
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire cic_evt_t evt_i,
  input wire logic [N_PCHG-1:0] pchg_evt,
  input wire logic ext_pin,
  input wire logic sleep_active,
  input wire logic return_from_isr_op,
  output cic_core_t core_o
);

  // Refuse pin-change widths the 8-bit register cannot hold
  if (N_PCHG < 1 || N_PCHG > 8)
  begin : g_bad_width
    $error("N_PCHG must be 1 to 8");
  end

  // Flag update: software value first, a same-cycle event always wins
  function automatic logic [7:0] upd8(input logic [7:0] cur, input logic wr,
                                      input logic [7:0] wd, input logic [7:0] evt);
    upd8 = (wr ? wd : cur) | evt;
  endfunction : upd8

  logic [7:0] ctl_r; // irq_control_reg, bit 0 unused in storage
  logic [7:0] pfa_r; // periph_flag_reg_a
  logic [7:0] pfb_r; // periph_flag_reg_b
  logic [7:0] pea_r; // periph_enable_regs, first
  logic [7:0] peb_r; // periph_enable_regs, second
  logic [7:0] pcf_r; // pin_change_flags, unused upper bits stay zero
  logic [7:0] opt_r; // ext_edge_select in bit 0
  logic [1:0] qph_r; // Q phase within the instruction cycle
  cic_state_t st_r; // Vectoring sequencer
  logic wake_hold_r; // Post-sleep instruction still to run
  logic sleep_d_r; // Previous sleep level
  cic_core_t core_r; // Registered core commands
  logic ext_s1_r, ext_s2_r, ext_s3_r; // Pin synchroniser
  logic ext_lvl_r; // Accepted pin level
  logic ext_prime_r; // First accepted level after reset
  logic ap_wr_r, ap_rd_r; // Pending data phase
  logic [7:0] ap_addr_r; // Captured byte offset
  logic hready_r, hresp_r;
  logic [31:0] hrdata_r;

  logic q1, wr_en, ext_edge, pc_sum, core_term, per_term, irq_req, wake_cond, take;
  logic [7:0] pc_evt8, wd8, pcf_wr;

  assign q1 = (qph_r == Q1_PH);
  assign wd8 = hwdata[7:0];
  assign wr_en = ap_wr_r;
  assign pc_evt8 = 8'(pchg_evt);
  assign pc_sum = |pcf_r;
  // Individual enables first, group enable for the peripheral registers
  assign core_term = (ctl_r[B_T0IE] & ctl_r[B_T0IF]) | (ctl_r[B_PIN_EN] & ctl_r[B_PIN_FLG])
                   | (ctl_r[B_IOCIE] & pc_sum);
  assign per_term = ctl_r[B_GRP_EN] & |((pfa_r & pea_r) | (pfb_r & peb_r));
  assign irq_req = ctl_r[B_GLB_EN] & (core_term | per_term);
  // Timer0 stops in Sleep, so only the pin, pin-change and masked peripherals wake
  assign wake_cond = (ctl_r[B_PIN_EN] & ctl_r[B_PIN_FLG]) | (ctl_r[B_IOCIE] & pc_sum)
                   | (ctl_r[B_GRP_EN] & |((pfa_r & pea_r & WAKE_MASK_A)
                   | (pfb_r & peb_r & WAKE_MASK_B)));
  // Sampled at Q1; held off in Sleep and the wake cycle so the next instruction runs first
  assign take = (st_r == S_IDLE) && q1 && irq_req && !wake_hold_r && !sleep_active && !sleep_d_r;
  // A change counts once the second and third flop agree
  assign ext_edge = ext_prime_r && (ext_s2_r == ext_s3_r) && (ext_s3_r != ext_lvl_r)
                  && (ext_s3_r == opt_r[B_EDGE]);
  assign pcf_wr = wd8 & 8'((1 << N_PCHG) - 1);

  // Q phase counter: instruction cycle timebase
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      qph_r <= Q1_PH;
    else if (ce)
      qph_r <= (qph_r == Q_LAST) ? Q1_PH : 2'(qph_r + 2'h1);
  end

  // Pin synchroniser; the first flop feeds only the second
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end
    else if (ce)
    begin
      ext_s1_r <= ext_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  // Accepted level; first agreement after reset only primes, so no false edge
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      ext_lvl_r <= 1'b0;
      ext_prime_r <= 1'b0;
    end
    else if (ce && ext_s2_r == ext_s3_r)
    begin
      ext_lvl_r <= ext_s3_r;
      ext_prime_r <= 1'b1;
    end
  end

  // irq_control_reg: enables by software, flags by events, global enable by sequencer
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      ctl_r <= RST_CTRL;
    else if (ce)
    begin
      // Writable bits take software value; flags OR in their events
      if (wr_en && ap_addr_r == OFF_CTRL)
        ctl_r[7:1] <= wd8[7:1];
      ctl_r[B_SUM_FLG] <= 1'b0;
      if (evt_i.tmr0_ovf)
        ctl_r[B_T0IF] <= 1'b1;
      if (ext_edge)
        ctl_r[B_PIN_FLG] <= 1'b1;
      // Vectoring clears the global enable ahead of return and software
      if (take)
        ctl_r[B_GLB_EN] <= 1'b0;
      else if (return_from_isr_op)
        ctl_r[B_GLB_EN] <= 1'b1;
    end
  end

  // Peripheral flag registers and pin-change flags
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      pfa_r <= RST_FLAG;
      pfb_r <= RST_FLAG;
      pcf_r <= RST_FLAG;
    end
    else if (ce)
    begin
      pfa_r <= upd8(pfa_r, wr_en && ap_addr_r == OFF_PFLG_A, wd8, evt_i.periph_a);
      pfb_r <= upd8(pfb_r, wr_en && ap_addr_r == OFF_PFLG_B, wd8, evt_i.periph_b);
      pcf_r <= upd8(pcf_r, wr_en && ap_addr_r == OFF_PCHG, pcf_wr, pc_evt8);
    end
  end

  // Enable and option registers, plain software state
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      pea_r <= RST_FLAG;
      peb_r <= RST_FLAG;
      opt_r <= RST_OPT;
    end
    else if (ce && wr_en)
    begin
      if (ap_addr_r == OFF_PEN_A)
        pea_r <= wd8;
      if (ap_addr_r == OFF_PEN_B)
        peb_r <= wd8;
      if (ap_addr_r == OFF_OPT)
        opt_r <= {7'h00, wd8[B_EDGE]};
    end
  end

  // Wake tracking: one instruction must run after Sleep before any vectoring
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      sleep_d_r <= 1'b0;
      wake_hold_r <= 1'b0;
    end
    else if (ce)
    begin
      sleep_d_r <= sleep_active;
      if (sleep_d_r && !sleep_active)
        wake_hold_r <= 1'b1;
      else if (q1 && st_r == S_IDLE)
        wake_hold_r <= 1'b0;
    end
  end

  // Sequencer: Q1 take, current instruction finishes, forced cycle, vector runs.
  // Moves only at Q1, so instruction length never changes the latency.
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      st_r <= S_IDLE;
    else if (ce && q1)
    begin
      case (st_r)
        S_IDLE:
          if (take)
            st_r <= S_FINISH;
        S_FINISH:
          st_r <= S_FORCE;
        S_FORCE:
          st_r <= S_IDLE;
        default:
          st_r <= S_IDLE;
      endcase
    end
  end

  // Core command register: flush level over the forced cycle, one-shot stack pulses
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      core_r <= '0;
    else if (ce)
    begin
      core_r.vector <= VECTOR_ADDR;
      core_r.q1 <= (qph_r == Q_LAST);
      core_r.wake <= sleep_active && wake_cond;
      core_r.pop_pc <= return_from_isr_op;
      core_r.restore_ctx <= return_from_isr_op;
      core_r.push_pc <= (st_r == S_FINISH) && q1;
      // Core shadows W, status less timeout and power-down, bank, both FSRs, PC latch
      core_r.save_ctx <= (st_r == S_FINISH) && q1;
      core_r.load_vector <= (st_r == S_FINISH) && q1;
      if (q1)
        core_r.flush <= (st_r == S_FINISH);
    end
  end

  // AHB-Lite slave: writes zero-wait, reads one wait state, always OKAY
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      ap_wr_r <= 1'b0;
      ap_rd_r <= 1'b0;
      ap_addr_r <= 8'h00;
      hready_r <= 1'b1;
      hresp_r <= 1'b0;
      hrdata_r <= 32'h0000_0000;
    end
    else if (ce)
    begin
      ap_wr_r <= 1'b0;
      ap_rd_r <= 1'b0;
      if (ap_rd_r)
      begin
        // Wait cycle: present the word, release the bus
        hready_r <= 1'b1;
        case (ap_addr_r)
          OFF_CTRL: hrdata_r <= {24'h000000, ctl_r[7:1], pc_sum};
          OFF_PFLG_A: hrdata_r <= {24'h000000, pfa_r};
          OFF_PFLG_B: hrdata_r <= {24'h000000, pfb_r};
          OFF_PEN_A: hrdata_r <= {24'h000000, pea_r};
          OFF_PEN_B: hrdata_r <= {24'h000000, peb_r};
          OFF_PCHG: hrdata_r <= {24'h000000, pcf_r};
          OFF_OPT: hrdata_r <= {24'h000000, opt_r};
          OFF_STAT: hrdata_r <= {27'h0000000, sleep_active, 2'(st_r), core_r.wake, irq_req};
          default: hrdata_r <= 32'h0000_0000;
        endcase
      end
      else if (hsel && htrans[1] && hready && hsize == 3'h2)
      begin
        // Address phase of a word transfer; other sizes are ignored
        ap_addr_r <= {haddr[7:2], 2'h0};
        ap_wr_r <= hwrite;
        ap_rd_r <= !hwrite;
        hready_r <= hwrite;
      end
    end
  end

  assign hreadyout = hready_r;
  assign hresp = hresp_r;
  assign hrdata = hrdata_r;
  assign core_o = core_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_enter;
    st_r == S_FINISH && q1 && ce;
  endsequence

  sequence s_force;
    core_r.flush && core_r.push_pc && core_r.save_ctx && core_r.load_vector
    && core_r.vector == VECTOR_ADDR;
  endsequence

  sequence s_take;
    st_r == S_IDLE && q1 && ce && irq_req && !wake_hold_r && !sleep_active && !sleep_d_r;
  endsequence

  a_reset_off: assert property (!$past(resetn) |-> !ctl_r[B_GLB_EN] && st_r == S_IDLE)
    else $error("interrupts enabled after reset");
  a_gate_enter: assert property ((st_r == S_IDLE) ##1 (st_r == S_FINISH) |-> $past(irq_req))
    else $error("vectoring without enables");
  a_flag_set: assert property (ce && evt_i.tmr0_ovf |=> ctl_r[B_T0IF])
    else $error("timer flag not set by event");
  a_vector_seq: assert property (s_enter |=> s_force ##1 !core_r.push_pc)
    else $error("forced cycle commands wrong");
  a_take_clear: assert property (s_take |=> st_r == S_FINISH && !ctl_r[B_GLB_EN])
    else $error("take did not clear global enable");
  a_global_quiet: assert property (!ctl_r[B_GLB_EN] && st_r == S_IDLE |=> st_r != S_FINISH)
    else $error("vectoring with global enable clear");
  a_return_op: assert property (ce && return_from_isr_op && !take
                                |=> ctl_r[B_GLB_EN] && core_r.pop_pc && core_r.restore_ctx)
    else $error("return did not restore");
  a_q1_only: assert property (ce && !q1 |=> $stable(st_r))
    else $error("sequencer moved off Q1");
  a_seq_len: assert property (s_enter |=> st_r == S_FORCE ##1 (st_r == S_FORCE)[*3])
    else $error("forced cycle too short");
  a_ext_flag: assert property (ce && ext_edge |=> ctl_r[B_PIN_FLG])
    else $error("pin edge lost");
  a_wake_first: assert property (wake_hold_r && q1 && ce && st_r == S_IDLE |=> st_r == S_IDLE)
    else $error("vectored before post-sleep instruction");
  a_sum_clear: assert property ($fell(pc_sum) |-> $past(wr_en && ap_addr_r == OFF_PCHG))
    else $error("summary flag cleared without write");

endmodule : cic_core_irq

// *** hw/cic_pkg.sv ***
// Constants, register map and carrier types of the core interrupt controller.
// Assumes a single 100 MHz mclk domain and an instruction cycle of four Q phases.
package cic_pkg;
  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PFLG_A = 8'h04;
  localparam logic [7:0] OFF_PFLG_B = 8'h08;
  localparam logic [7:0] OFF_PEN_A = 8'h0C;
  localparam logic [7:0] OFF_PEN_B = 8'h10;
  localparam logic [7:0] OFF_PCHG = 8'h14;
  localparam logic [7:0] OFF_OPT = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1C;
  // Field positions in irq_control_reg
  localparam int B_GLB_EN = 7;
  localparam int B_GRP_EN = 6;
  localparam int B_T0IE = 5;
  localparam int B_PIN_EN = 4;
  localparam int B_IOCIE = 3;
  localparam int B_T0IF = 2;
  localparam int B_PIN_FLG = 1;
  localparam int B_SUM_FLG = 0;
  // Edge select position in the option register
  localparam int B_EDGE = 0;
  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_FLAG = 8'h00;
  localparam logic [7:0] RST_OPT = 8'h01;
  // Fixed interrupt vector
  localparam logic [15:0] VECTOR_ADDR = 16'h0004;
  // Q phase counter: Q1 is phase 0, four phases per instruction cycle
  localparam logic [1:0] Q1_PH = 2'h0;
  localparam logic [1:0] Q_LAST = 2'h3;
  // Vectoring sequencer states
  typedef enum logic [1:0] {S_IDLE, S_FINISH, S_FORCE} cic_state_t;
  // Event pulses from core and peripheral sources
  typedef struct packed {
    logic tmr0_ovf;
    logic [7:0] periph_a;
    logic [7:0] periph_b;
  } cic_evt_t;
  // Commands to the core pipeline and stack
  typedef struct packed {
    logic flush;
    logic push_pc;
    logic save_ctx;
    logic load_vector;
    logic pop_pc;
    logic restore_ctx;
    logic wake;
    logic q1;
    logic [15:0] vector;
  } cic_core_t;
endpackage : cic_pkg

// *** tb/cic_core_irq_tb_top.sv ***
// Self-checking bench: register bus, flags, enables, vectoring, pin edges, sleep.
// Assumes cic_core_model stands in for the core and hready loops back from hreadyout.
`timescale 1ns/1ns
module cic_core_irq_tb_top
  import cic_pkg::*;
  ;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b1;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic ext_pin = 1'b0;
  logic ret_req = 1'b0;
  logic sleep_req = 1'b0;
  logic [5:0] pchg = '0;
  cic_evt_t evt = '0;
  logic hreadyout, hresp, ret_op, sleep_act;
  logic [31:0] hrdata, rd;
  logic [15:0] pc;
  logic [3:0] depth;
  cic_core_t core;
  int errors = 0;
  int n_tests = 0;
  // 100 MHz clock
  always #5 mclk = ~mclk;
  cic_core_irq #(.N_PCHG(6)) i_cic_core_irq (.mclk(mclk), .resetn(resetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .evt_i(evt), .pchg_evt(pchg),
    .ext_pin(ext_pin), .sleep_active(sleep_act), .return_from_isr_op(ret_op), .core_o(core));
  cic_core_model i_cic_core_model (.mclk(mclk), .resetn(resetn), .core_o(core), .ret_req(ret_req),
    .sleep_req(sleep_req), .return_from_isr_op(ret_op), .sleep_active(sleep_act), .pc(pc), .depth(depth));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt
  // Single word transfer; each phase holds until hready is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, {24'h0, exp}, rd);
  endtask : rdc
  // One-cycle event pulses
  task automatic ev(input cic_evt_t e, input logic [5:0] p);
    @(posedge mclk);
    evt <= e;
    pchg <= p;
    @(posedge mclk);
    evt <= '0;
    pchg <= '0;
  endtask : ev
  // Edges from the event until the forced cycle ends; two instruction cycles are the floor
  task automatic lat(input int hi);
    int n;
    n = 1;
    while (core.flush !== 1'b1 && n < 40)
    begin
      @(posedge mclk);
      n++;
    end
    while (core.flush !== 1'b0 && n < 40)
    begin
      @(posedge mclk);
      n++;
    end
    chk("latency", 32'h1, {31'h0, n >= 8 && n <= hi});
  endtask : lat
  task automatic ret;
    @(posedge mclk);
    ret_req <= 1'b1;
    @(posedge mclk);
    ret_req <= 1'b0;
    wt(4);
  endtask : ret
  task automatic t_reset;
    rdc("ctrl", OFF_CTRL, RST_CTRL);
    rdc("option", OFF_OPT, RST_OPT);
    wr(8'h40, 8'hFF);
    rdc("unmapped", 8'h40, 8'h00);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : t_reset
  // Flags record with every enable off, and nothing vectors
  task automatic t_flags;
    ev('{tmr0_ovf: 1'b1, periph_a: 8'h01, periph_b: 8'h80}, 6'h00);
    wt(20);
    rdc("ctrl", OFF_CTRL, 8'h04);
    rdc("flag_a", OFF_PFLG_A, 8'h01);
    rdc("flag_b", OFF_PFLG_B, 8'h80);
    chk("depth", 32'h0, {28'h0, depth});
  endtask : t_flags
  // Peripheral source waits for the group enable, then vectors and returns
  task automatic t_group;
    wr(OFF_PEN_A, 8'h01);
    wr(OFF_CTRL, 8'h80);
    wt(20);
    chk("depth", 32'h0, {28'h0, depth});
    wr(OFF_CTRL, 8'hC0);
    wt(20);
    chk("depth", 32'h1, {28'h0, depth});
    chk("pc", 32'h4, {16'h0, pc});
    rdc("ctrl", OFF_CTRL, 8'h40);
    wr(OFF_PFLG_A, 8'h00);
    wr(OFF_PFLG_B, 8'h00);
    ret;
    chk("depth", 32'h0, {28'h0, depth});
    rdc("ctrl", OFF_CTRL, 8'hC0);
  endtask : t_group
  task automatic t_sync;
    wr(OFF_CTRL, 8'hA0);
    ev('{tmr0_ovf: 1'b1, default: '0}, 6'h00);
    lat(16);
    wr(OFF_CTRL, 8'h20);
    ret;
    chk("depth", 32'h0, {28'h0, depth});
  endtask : t_sync
  // Both edge selections: only the selected edge sets the pin flag
  task automatic t_pin;
    for (int k = 0; k < 4; k++)
    begin
      wr(OFF_OPT, {7'h0, k < 2});
      wr(OFF_CTRL, 8'h10);
      ext_pin <= ~ext_pin;
      wt(20);
      rdc("pin_flag", OFF_CTRL, {6'h04, ext_pin == (k < 2), 1'b0});
    end
    wr(OFF_OPT, 8'h01);
    wr(OFF_CTRL, 8'h90);
    ext_pin <= 1'b1;
    lat(20);
    rdc("ctrl", OFF_CTRL, 8'h12);
    wr(OFF_CTRL, 8'h00);
    ret;
  endtask : t_pin
  // Summary flag follows all pin-change flags and ignores writes
  task automatic t_summary;
    wr(OFF_CTRL, 8'h08);
    ev('0, 6'h05);
    rdc("summary", OFF_CTRL, 8'h09);
    wr(OFF_CTRL, 8'h08);
    rdc("summary", OFF_CTRL, 8'h09);
    wr(OFF_PCHG, 8'h04);
    rdc("summary", OFF_CTRL, 8'h09);
    wr(OFF_PCHG, 8'h00);
    rdc("summary", OFF_CTRL, 8'h08);
  endtask : t_summary
  // Wake on an enabled peripheral; one instruction runs before the vector
  task automatic t_sleep;
    int n;
    wr(OFF_CTRL, 8'hC0);
    @(posedge mclk);
    sleep_req <= 1'b1;
    @(posedge mclk);
    sleep_req <= 1'b0;
    wt(8);
    ev('{periph_a: 8'h01, default: '0}, 6'h00);
    for (n = 0; n < 20 && sleep_act; n++) @(posedge mclk);
    chk("asleep", 32'h0, {31'h0, sleep_act});
    for (n = 0; n < 40 && core.flush !== 1'b1; n++) @(posedge mclk);
    chk("wake_delay", 32'h1, {31'h0, n >= 4 && n <= 16});
    wr(OFF_PFLG_A, 8'h00);
    ret;
  endtask : t_sleep
  task automatic test_done;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  // Main sequence after ten reset cycles
  initial
  begin
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    t_reset;
    t_flags;
    t_group;
    t_sync;
    t_pin;
    t_summary;
    t_sleep;
    test_done;
  end
  // Tests need about four hundred cycles; fifty times that means a hang
  initial
  begin
    #200000;
    errors++;
    test_done;
  end
endmodule : cic_core_irq_tb_top

// *** tb/cic_core_model.sv ***
// Behavioural core for the interrupt controller: stack depth, PC, sleep, return.
// Assumes core_o commands from cic_core_irq on the same mclk, requests from the bench.
`timescale 1ns/1ns
module cic_core_model
  import cic_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire cic_core_t core_o,
  input wire logic ret_req,
  input wire logic sleep_req,
  output logic return_from_isr_op,
  output logic sleep_active,
  output logic [15:0] pc,
  output logic [3:0] depth
);
  // Core state follows the controller's commands one cycle at a time
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      return_from_isr_op <= 1'b0;
      sleep_active <= 1'b0;
      pc <= 16'h0000;
      depth <= 4'h0;
    end
    else
    begin
      // Return instruction lasts one cycle per request
      return_from_isr_op <= ret_req;
      // Sleep holds until a wake source is reported; enables are set beforehand
      sleep_active <= sleep_req | (sleep_active & ~core_o.wake);
      if (core_o.load_vector)
        pc <= core_o.vector;
      // Stack depth shows pushes and pops without modelling contents
      depth <= depth + {3'h0, core_o.push_pc} - {3'h0, core_o.pop_pc};
    end
  end
endmodule : cic_core_model
